/* File: logic/port_mapper.sv */
// port mapper: packs a pixel pair and qualifiers into the transmitter word
`timescale 1ns/1ns
module port_mapper
  import two_tap_pkg::*;
(
  input  wire depth_type      depth,
  input  wire pixel_pair_type pair,
  input  wire logic           lv,
  input  wire logic           fv,
  input  wire logic           dv,
  output link_word_type       word
);

  logic [PIX_W-1:0] p0;
  logic [PIX_W-1:0] p1;

  assign p0 = pair.first_pixel_stream;
  assign p1 = pair.second_pixel_stream;

  always_comb begin
    word             = '0;
    word.line_valid  = lv;
    word.frame_valid = fv;
    word.data_valid  = dv;
    word.spare       = 1'b0;
    unique case (depth)
      DEPTH_12: begin
        word.port_a = p0[7:0];
        word.port_b = {p1[11:8], p0[11:8]};
        word.port_c = p1[7:0];
      end
      DEPTH_10: begin
        word.port_a = p0[9:2];
        word.port_b = {2'b00, p1[11:10], 2'b00, p0[11:10]};
        word.port_c = p1[9:2];
      end
      DEPTH_8: begin
        word.port_a = p0[11:4];
        word.port_b = p1[11:4];
      end
      default: begin
        word.port_a = 8'h00;
      end
    endcase
  end

endmodule : port_mapper

/* File: logic/two_tap_line_video_output.sv */
// top: two-tap line video output formatter with avalon register slave
`timescale 1ns/1ns
module two_tap_line_video_output
  import two_tap_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [ADDR_W-1:0]    avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 link_pclk,
  input  wire logic                 line_start,
  input  wire logic [2*PIX_W-1:0]   pix_pair_in,
  output logic                      pix_req,
  output link_word_type             link_out,
  output logic                      link_clk_out
);

  // ****************************************************************************
  // register slave
  // ****************************************************************************
  logic [31:0] mode_ff;
  logic [31:0] fvlen_ff;
  logic [31:0] line_ff;
  logic        ack_ff;
  logic        busy_ff;
  logic [31:0] nxt_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // one wait cycle: request taken at the edge where waitrequest is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end
  // registered so every top output leaves a flip-flop; it always equals ~ack_ff
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_ff);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff  <= MODE_RESET;
      fvlen_ff <= FVLEN_RESET;
      line_ff  <= LINE_RESET;
    end else if (avs_write && ack_ff) begin
      unique case (avs_address)
        OFS_MODE:  mode_ff  <= merge(mode_ff, avs_writedata, avs_byteenable);
        OFS_FVLEN: fvlen_ff <= merge(fvlen_ff, avs_writedata, avs_byteenable);
        OFS_LINE:  line_ff  <= merge(line_ff, avs_writedata, avs_byteenable);
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    unique case (avs_address)
      OFS_MODE:   nxt_rdata = mode_ff;
      OFS_FVLEN:  nxt_rdata = fvlen_ff;
      OFS_LINE:   nxt_rdata = line_ff;
      OFS_STATUS: nxt_rdata = {31'h0000_0000, busy_ff};
      default:    nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      avs_readdata <= nxt_rdata;
    end
  end

  // ****************************************************************************
  // link clock and start synchronisers
  // ****************************************************************************
  logic pclk_s1_ff;
  logic pclk_s2_ff;
  logic pclk_d_ff;
  logic start_s1_ff;
  logic start_s2_ff;
  logic start_d_ff;
  logic rise;
  logic start_edge;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pclk_s1_ff  <= 1'b0;
      pclk_s2_ff  <= 1'b0;
      pclk_d_ff   <= 1'b0;
      start_s1_ff <= 1'b0;
      start_s2_ff <= 1'b0;
      start_d_ff  <= 1'b0;
    end else begin
      pclk_s1_ff  <= link_pclk;
      pclk_s2_ff  <= pclk_s1_ff;
      pclk_d_ff   <= pclk_s2_ff;
      start_s1_ff <= line_start;
      start_s2_ff <= start_s1_ff;
      start_d_ff  <= start_s2_ff;
    end
  end

  assign rise       = pclk_s2_ff & ~pclk_d_ff;
  assign start_edge = start_s2_ff & ~start_d_ff;

  // strobe is carried on the same transmitter as the data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_clk_out <= 1'b0;
    end else begin
      link_clk_out <= pclk_s2_ff;
    end
  end

  // ****************************************************************************
  // line sequencer
  // ****************************************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_PIX   = 2'b10
  } seq_type;

  seq_type     state_ff;
  logic        pend_ff;
  logic [1:0]  lead_ff;
  logic [15:0] pairs_ff;
  logic        fv_ff;
  logic        lv_ff;
  logic        dv_ff;
  logic        req_ff;
  depth_type   depth;
  acq_type     acq;
  logic        fv_allowed;
  logic [15:0] line_pairs;

  assign depth      = depth_type'(mode_ff[MODE_DEPTH_LSB +: 2]);
  assign acq        = acq_type'(mode_ff[MODE_ACQ_LSB +: 2]);
  // mode clock bit is only stored; both rates give the same two-period lead
  assign fv_allowed = (acq != ACQ_RGB) && (fvlen_ff[LEN_W-1:0] != 16'h0000);
  assign line_pairs = {1'b0, line_ff[15:1]};

  // a start seen between link edges or during a line is held until the next rising edge in idle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_ff <= 1'b0;
    end else if (start_edge) begin
      pend_ff <= 1'b1;
    end else if (rise && state_ff == ST_IDLE) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      lead_ff  <= 2'b00;
      pairs_ff <= 16'h0000;
      fv_ff    <= 1'b0;
      lv_ff    <= 1'b0;
      dv_ff    <= 1'b0;
      req_ff   <= 1'b0;
      busy_ff  <= 1'b0;
    end else begin
      req_ff <= 1'b0;
      if (rise) begin
        unique case (state_ff)
          ST_IDLE: begin
            fv_ff <= 1'b0;
            lv_ff <= 1'b0;
            dv_ff <= 1'b0;
            if (pend_ff && line_pairs != 16'h0000) begin
              // lead is timed even when frame valid is suppressed
              fv_ff    <= fv_allowed;
              lead_ff  <= 2'(LV_EXTRA_CYC - 1);
              state_ff <= ST_LEAD;
              busy_ff  <= 1'b1;
            end
          end
          ST_LEAD: begin
            // depth plays no part in this wait
            if (lead_ff == 2'b00) begin
              lv_ff    <= 1'b1;
              dv_ff    <= 1'b1;
              req_ff   <= 1'b1;
              pairs_ff <= line_pairs - 16'h0001;
              state_ff <= ST_PIX;
            end else begin
              lead_ff <= lead_ff - 2'b01;
            end
          end
          ST_PIX: begin
            if (pairs_ff == 16'h0000) begin
              fv_ff    <= 1'b0;
              lv_ff    <= 1'b0;
              dv_ff    <= 1'b0;
              state_ff <= ST_IDLE;
              busy_ff  <= 1'b0;
            end else begin
              req_ff   <= 1'b1;
              pairs_ff <= pairs_ff - 16'h0001;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign pix_req = req_ff;

  // ****************************************************************************
  // output word register
  // ****************************************************************************
  pixel_pair_type pair_ff;
  link_word_type  word;
  logic           fv_out;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pair_ff <= '0;
    end else if (req_ff) begin
      pair_ff <= pixel_pair_type'(pix_pair_in);
    end
  end

  assign fv_out = fv_ff & fv_allowed;

  port_mapper u_map (
    .depth (depth),
    .pair  (pair_ff),
    .lv    (lv_ff),
    .fv    (fv_out),
    .dv    (dv_ff),
    .word  (word)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_out <= '0;
    end else begin
      link_out <= word;
    end
  end

  // ****************************************************************************
  // checks
  // ****************************************************************************
  a_quals_together: assert property (@(posedge clk) disable iff (sys_rst)
    link_out.data_valid == link_out.line_valid)
    else $error("data valid and line valid differ");

  // the output word lags the mode by one register, hence the past value
  a_rgb_no_fv: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(acq) == ACQ_RGB) |-> !link_out.frame_valid)
    else $error("frame valid in rgb mode");

  a_zero_len_no_fv: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(fvlen_ff[LEN_W-1:0]) == 16'h0000) |-> !link_out.frame_valid)
    else $error("frame valid with zero length");

  a_spare_low: assert property (@(posedge clk) disable iff (sys_rst)
    !link_out.spare)
    else $error("spare bit driven");

  a_depth8_c_low: assert property (@(posedge clk) disable iff (sys_rst)
    $past(depth) == DEPTH_8 && $past(depth, 2) == DEPTH_8 |-> link_out.port_c == 8'h00)
    else $error("port c used at 8 bit");

  a_depth10_gaps: assert property (@(posedge clk) disable iff (sys_rst)
    $past(depth) == DEPTH_10 |->
      link_out.port_b[7:6] == 2'b00 && link_out.port_b[3:2] == 2'b00)
    else $error("unused port b bits driven at 10 bit");

  a_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (state_ff == ST_IDLE && $past(state_ff) == ST_IDLE) |-> !lv_ff && !dv_ff && !fv_ff)
    else $error("qualifier high while idle");

  a_lv_lead: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(lv_ff) |-> $past(state_ff) == ST_LEAD && $past(lead_ff) == 2'b00)
    else $error("line valid without lead");

  a_fv_leads_lv: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(fv_ff) |-> !lv_ff)
    else $error("frame valid rose after line valid");

  a_lv_fall_all: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(lv_ff) |-> !fv_ff && !dv_ff)
    else $error("qualifiers did not fall together");

  a_launch_on_edge: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(lv_ff) |-> $past(rise))
    else $error("qualifier moved off link edge");

  a_start_on_edge: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(busy_ff) |-> $past(pend_ff) && $past(rise))
    else $error("line started without a pending start on a link edge");

  a_req_in_line: assert property (@(posedge clk) disable iff (sys_rst)
    req_ff |-> lv_ff && state_ff == ST_PIX)
    else $error("pixel request outside a line");

  a_req_single: assert property (@(posedge clk) disable iff (sys_rst)
    req_ff |=> !req_ff)
    else $error("pixel request longer than one cycle");

  // exactly one wait state, then the slave is ready for the next request
  a_wait_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait state");

  a_wait_released: assert property (@(posedge clk) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  c_line_sent:  cover property (@(posedge clk) $fell(lv_ff));
  c_raw_fv:     cover property (@(posedge clk) $rose(fv_out));
  c_depth10:    cover property (@(posedge clk) lv_ff && depth == DEPTH_10);
  c_held_start: cover property (@(posedge clk) start_edge && state_ff != ST_IDLE);
  c_zero_len:   cover property (@(posedge clk) lv_ff && acq != ACQ_RGB && !fv_out);

endmodule : two_tap_line_video_output

/* File: logic/two_tap_pkg.sv */
// package: constants and carrier types of the two-tap line video output
// ****************************************************************************
// Summary of operation
// - each pixel clock carries two pixel values plus line and data valid bits.
// - frame valid only in raw modes, and never when its length setting is zero.
// - all pixel, qualifier and clock bits use the first transmitter only.
// - every output word is launched on a rising edge of the pixel clock.
// - in raw modes frame valid marks that each line is sent.
// - at 10-bit depth the two lowest sample bits are dropped.
// - at 8-bit depth the four lowest sample bits are dropped.
// - line and data valid stay low on every cycle without valid pixel data.
// - first cycle sends pixels 1 and 2, then advances two pixels per cycle.
// - after the last pair all three qualifiers fall together.
// - line valid rises two link clock periods after frame valid.
// - with zero frame valid length, line valid keeps the full delay anyway.
// - bit depth never changes the line or frame valid delay.
// - port A/B/C mapping depends on bit depth; unused bits stay low.
// - link pixel clock is 40 MHz or 80 MHz, chosen by configuration; the design only follows link_pclk and the mode clock bit drives nothing.
// - software selects depth through the mode field of the output mode register.
// ****************************************************************************
package two_tap_pkg;

  localparam int ADDR_W = 4;
  localparam int PIX_W  = 12;
  localparam int LEN_W  = 16;

  // register byte offsets on the avalon slave
  localparam logic [ADDR_W-1:0] OFS_MODE   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FVLEN  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_LINE   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;

  // mode register fields
  localparam int MODE_DEPTH_LSB = 0;
  localparam int MODE_ACQ_LSB   = 4;
  localparam int MODE_CLK_BIT   = 8;

  localparam logic [31:0] MODE_RESET  = 32'h0000_0000;
  localparam logic [31:0] FVLEN_RESET = 32'h0000_0001;
  localparam logic [31:0] LINE_RESET  = 32'h0000_0800;

  // line valid lags frame valid by two link clock periods at either speed
  localparam int LV_EXTRA_CYC = 2;

  typedef enum logic [1:0] {
    DEPTH_12 = 2'b00,
    DEPTH_10 = 2'b01,
    DEPTH_8  = 2'b10
  } depth_type;

  typedef enum logic [1:0] {
    ACQ_RGB     = 2'b00,
    ACQ_RAW     = 2'b01,
    ACQ_ENH_RAW = 2'b10
  } acq_type;

  typedef struct packed {
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic [7:0] port_c;
    logic       line_valid;
    logic       frame_valid;
    logic       data_valid;
    logic       spare;
  } link_word_type;

  typedef struct packed {
    logic [PIX_W-1:0] first_pixel_stream;
    logic [PIX_W-1:0] second_pixel_stream;
  } pixel_pair_type;

endpackage : two_tap_pkg

/* File: verification/frame_grabber_model.sv */
// frame grabber model: decodes the accepted two-tap link words
`timescale 1ns/1ns
module frame_grabber_model
  import two_tap_pkg::*;
(
  input  wire logic          strobe,
  input  wire link_word_type word,
  input  wire depth_type     depth,
  input  wire logic          need_fv,
  output pixel_pair_type     pair,
  output logic               junk,
  output int                 words
);
  initial words = 0;
  // sampled mid-period, so a word launched on the rising strobe has settled
  always @(negedge strobe) begin
    if (word.line_valid && word.data_valid && (word.frame_valid || !need_fv)) begin
      case (depth)
        DEPTH_12: pair <= {word.port_b[3:0], word.port_a, word.port_b[7:4], word.port_c};
        DEPTH_10: pair <= {2'h0, word.port_b[1:0], word.port_a, 2'h0, word.port_b[5:4],
                           word.port_c};
        default:  pair <= {4'h0, word.port_a, 4'h0, word.port_b};
      endcase
      junk  <= word.spare | (depth == DEPTH_10 && |{word.port_b[7:6], word.port_b[3:2]})
               | (depth == DEPTH_8 && |word.port_c);
      words <= words + 1;
    end
  end
endmodule : frame_grabber_model

/* File: verification/test_two_tap_line_video_output.sv */
// testbench: register setup, one line in each mode, a start held during a line
`timescale 1ns/1ns
module test_two_tap_line_video_output import two_tap_pkg::*;;
  localparam int PIXELS = 16;
  typedef struct {depth_type d; acq_type a; logic f80; logic [15:0] fvl; logic fv;} row_type;
  row_type rows [6] = '{
    '{DEPTH_12, ACQ_RGB, 1'h0, 16'h0001, 1'h0},
    '{DEPTH_10, ACQ_RAW, 1'h0, 16'h0001, 1'h1},
    '{DEPTH_8, ACQ_ENH_RAW, 1'h1, 16'h0001, 1'h1},
    '{DEPTH_12, ACQ_RAW, 1'h1, 16'h0000, 1'h0},
    '{DEPTH_10, ACQ_RGB, 1'h1, 16'h0003, 1'h0},
    '{DEPTH_8, ACQ_RAW, 1'h0, 16'h0005, 1'h1}};
  row_type        cur;
  logic           clk = 0, sys_rst = 1, rd = 0, wr = 0, lclk = 0, start = 0;
  logic [3:0]     addr = 4'h0;
  logic [31:0]    wdata = 32'h0, rdata, q;
  logic [23:0]    pin;
  logic           wreq, req, lstr, junk, lv_d = 0;
  link_word_type  lw;
  pixel_pair_type gp;
  int             gw, bad_count = 0, compares = 0, k = 0, j = 0, sh = 0, gap = 0;
  int             reqs = 0, t = 0;

  always #5 clk = ~clk;
  always #80 lclk = ~lclk;

  two_tap_line_video_output dut (.clk(clk), .sys_rst(sys_rst), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .link_pclk(lclk), .line_start(start),
    .pix_pair_in(pin), .pix_req(req), .link_out(lw), .link_clk_out(lstr));
  frame_grabber_model grabber (.strobe(lstr), .word(lw), .depth(cur.d), .need_fv(cur.fv),
    .pair(gp), .junk(junk), .words(gw));

  // ****
  // helpers
  // ****
  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tmo();
    chk("timeout", 32'h0, 32'h1);
    results();
  endtask : tmo

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (wreq === 1'h0) break;
    end
    if (n == 50) tmo();
    q = rdata;
    rd <= 0;
    wr <= 0;
  endtask : bus

  task automatic pulse();
    @(posedge clk);
    start <= 1;
    repeat (20) @(posedge clk);
    start <= 0;
  endtask : pulse

  task automatic run_line(input int lines);
    int n, w0, r0;
    w0 = gw;
    r0 = reqs;
    pulse();
    // a second start while the line runs must wait until it ends
    if (lines == 2) begin
      for (n = 0; n < 500 && lw.line_valid !== 1'h1; n++) @(posedge clk);
      if (n == 500) tmo();
      pulse();
    end
    for (n = 0; n < 5000 && gw != w0 + lines * PIXELS / 2; n++) @(posedge clk);
    if (n == 5000) tmo();
    repeat (200) @(posedge clk);
    chk("words", lines * PIXELS / 2, gw - w0);
    chk("reqs", lines * PIXELS / 2, reqs - r0);
    chk("idle", 32'h0, {lw.line_valid, lw.frame_valid, lw.data_valid});
  endtask : run_line

  // sensor side: pair k carries pixels 2k+1 and 2k+2 of the line
  function automatic logic [11:0] pix(input int n);
    pix = 12'(n * 291 + 7);
  endfunction : pix

  // the pair stands before the request, since the design samples it one edge after
  assign pin = {pix(2 * k + 1), pix(2 * k + 2)};

  always @(posedge clk) if (req === 1'h1) begin
    k <= (k + 1) % (PIXELS / 2);
    reqs <= reqs + 1;
  end

  always @(gw) if (gw > 0) begin
    chk("pair", {12'(pix(2 * j + 1) >> sh), 12'(pix(2 * j + 2) >> sh)}, gp);
    chk("unused", 32'h0, junk);
    j = (j + 1) % (PIXELS / 2);
  end

  always @(negedge lstr) begin
    chk("dv", lw.line_valid, lw.data_valid);
    if (!cur.fv) chk("fv", 32'h0, lw.frame_valid);
    if (lw.line_valid && !lv_d && cur.fv) chk("gap", LV_EXTRA_CYC, gap);
    if (!lw.line_valid && lv_d) chk("fall", 32'h0, lw.frame_valid);
    gap = (lw.frame_valid && !lw.line_valid) ? gap + 1 : 0;
    lv_d = lw.line_valid;
  end

  // ****
  // main sequence
  // ****
  initial begin
    cur = rows[0];
    repeat (16) @(posedge clk);
    chk("rst_word", 32'h0, lw);
    chk("rst_wait", 32'h1, wreq);
    sys_rst <= 0;
    bus(0, OFS_MODE, 32'h0);
    chk("mode", MODE_RESET, q);
    bus(0, OFS_FVLEN, 32'h0);
    chk("fvlen", FVLEN_RESET, q);
    bus(0, OFS_LINE, 32'h0);
    chk("line", LINE_RESET, q);
    bus(0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1, OFS_LINE, PIXELS);
    foreach (rows[i]) begin
      cur = rows[i];
      sh = (cur.d == DEPTH_12) ? 0 : (cur.d == DEPTH_10) ? 2 : 4;
      bus(1, OFS_MODE, {23'h0, cur.f80, 2'h0, cur.a, 2'h0, cur.d});
      bus(1, OFS_FVLEN, {16'h0, cur.fvl});
      bus(0, OFS_MODE, 32'h0);
      chk("mode_rb", {23'h0, cur.f80, 2'h0, cur.a, 2'h0, cur.d}, q);
      run_line(1);
    end
    run_line(2);
    bus(0, OFS_STATUS, 32'h0);
    chk("busy_end", 32'h0, q);
    // a line cut by reset: outputs drop at once, registers return to defaults
    pulse();
    for (t = 0; t < 500 && lw.line_valid !== 1'h1; t++) @(posedge clk);
    if (t == 500) tmo();
    bus(0, OFS_STATUS, 32'h0);
    chk("busy_line", 32'h1, q);
    sys_rst <= 1;
    repeat (3) @(posedge clk);
    chk("cut_word", 32'h0, lw);
    chk("cut_req", 32'h0, req);
    chk("cut_wait", 32'h1, wreq);
    sys_rst <= 0;
    bus(0, OFS_LINE, 32'h0);
    chk("line_rst", LINE_RESET, q);
    bus(0, OFS_MODE, 32'h0);
    chk("mode_rst", MODE_RESET, q);
    bus(0, OFS_STATUS, 32'h0);
    chk("busy_rst", 32'h0, q);
    repeat (400) @(posedge clk);
    chk("after_rst", 32'h0, lw);
    results();
  end
endmodule : test_two_tap_line_video_output
